// ==== hdl/touch_ctrl_map.vh ====
// register map, field positions, reset values and timing counts of the touch channel control
`ifndef TOUCH_CTRL_MAP_VH
`define TOUCH_CTRL_MAP_VH

// register indexes; byte address is four times the index
`define IDX_STATUS 6'h02
`define IDX_GEN_CONFIG 6'h20
`define IDX_TIMING_CONFIG 6'h22
`define IDX_PRESS_CONFIG 6'h23
`define IDX_SAMPLE_CONFIG 6'h24
`define IDX_CAL_TRIGGER 6'h26
`define IDX_ALERT_ENABLE 6'h27
`define IDX_REPEAT_ENABLE 6'h28

// reset values
`define RST_RELEASE_CTRL 1'b0
`define RST_REPEAT_INTERVAL 4'h4
`define RST_PRESS_THRESH 4'h7
`define RST_SAMPLES 3'h3
`define RST_CYCLE_TIME 2'h1
`define RST_CAL_TRIGGER 6'h00
`define RST_ALERT_ENABLE 6'h3f
`define RST_REPEAT_ENABLE 6'h3f

// field positions
`define POS_CAL_FAILED 0
`define POS_RELEASE_CTRL 0
`define POS_SAMPLES 4
`define POS_CYCLE_TIME 0

// calibration value limits
`define CAL_VALUE_MIN 10'h000
`define CAL_VALUE_MAX 10'h3ff

// timing at 25 MHz: one 35 ms step of the cycle, press and repeat timers
`define STEP_CYCLES 20'hd_59f8
// one 1.28 ms sample unit; sample time is fixed, not programmable here
`define SAMPLE_UNIT_CYCLES 16'h7d00

`endif

// ==== hdl/touch_chan_ctrl.v ====
// sensing cycle, calibration trigger and per-channel alert and repeat control of six touch inputs
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps
`default_nettype none
`include "touch_ctrl_map.vh"

module touch_chan_ctrl #(
    parameter [19:0] STEP_CYCLES = `STEP_CYCLES,
    parameter [15:0] SAMPLE_UNIT_CYCLES = `SAMPLE_UNIT_CYCLES
) (
    input wire clk_i,
    input wire rst_i,
    // classic wishbone slave
    input wire cyc_i,
    input wire stb_i,
    input wire we_i,
    input wire [7:0] adr_i,
    input wire [3:0] sel_i,
    input wire [31:0] dat_i,
    output reg [31:0] dat_o,
    output reg ack_o,
    // power state and channel enables from the device control logic
    input wire [5:0] active_en_i,
    input wire [5:0] standby_en_i,
    input wire standby_i,
    input wire deep_sleep_i,
    // per-channel touch and noise status from the measurement logic
    input wire [5:0] touch_status_i,
    input wire [5:0] noise_i,
    // analog calibration engine handshake
    output reg cal_start_o,
    output reg [2:0] cal_chan_o,
    input wire cal_done_i,
    input wire [9:0] cal_value_i,
    // sensing cycle phases
    output reg cycle_start_o,
    output reg sampling_o,
    output wire low_power_o,
    // alert requests, one-cycle pulses per channel
    output reg [5:0] alert_chan_o,
    output wire alert_req_o
);

    // engine states
    localparam [1:0] CAL_IDLE = 2'd0;
    localparam [1:0] CAL_START = 2'd1;
    localparam [1:0] CAL_WAIT = 2'd2;

    // software-visible control, plus calibration values that no register reads back
    reg [5:0] cal_req; // calibration trigger and failure bits
    reg [5:0] alert_en; // per-channel alert enables
    reg [5:0] repeat_en; // per-channel repeat enables
    reg [3:0] repeat_interval; // repeat step code
    reg [3:0] press_thresh; // press-and-hold threshold code
    reg [2:0] samples_per_measure; // log2 of samples per measurement
    reg [1:0] cycle_time; // programmed sensing cycle code
    reg release_irq_ctrl; // low enables release alerts
    reg analog_cal_failed; // sticky failure flag
    reg [9:0] chan_cal_value [0:5]; // last analog calibration values
    // bus decode; a write lands at the edge that samples ack, where the master ends it
    wire bus_req = cyc_i & stb_i & ~ack_o;
    wire bus_wr = cyc_i & stb_i & ack_o & we_i & sel_i[0];
    wire [5:0] idx = adr_i[7:2];
    wire [7:0] wbyte = dat_i[7:0];
    // enables seen by the sensing logic
    wire [5:0] eff_en = deep_sleep_i ? 6'h00 : (standby_i ? standby_en_i : active_en_i);
    reg [5:0] eff_en_q; // previous enables, zero after reset
    wire [5:0] newly_en = eff_en & ~eff_en_q;

    // calibration engine
    reg [1:0] cal_state;
    reg [2:0] cur_chan;
    reg [5:0] fail_mask; // channels that failed and wait for a new request
    reg routine_fail; // failure seen during the running routine
    reg [5:0] next_cal_req;
    reg next_fail_flag;

    // lowest pending channel at or above a start point
    function [3:0] pick_chan;
        input [5:0] pend;
        input [2:0] from;
        integer k;
        begin
            pick_chan = 4'h8;
            for (k = 5; k >= 0; k = k - 1) begin
                if (pend[k] && (k >= from)) begin
                    pick_chan = k[3:0];
                end
            end
        end
    endfunction
    // number of enabled inputs, summed at three bits so six fits
    wire [2:0] n_en = {2'b00, eff_en[0]} + {2'b00, eff_en[1]} + {2'b00, eff_en[2]}
        + {2'b00, eff_en[3]} + {2'b00, eff_en[4]} + {2'b00, eff_en[5]};
    wire [5:0] pending = cal_req & ~fail_mask;
    wire [3:0] first_chan = pick_chan(pending, 3'd0);
    wire [3:0] after_chan = pick_chan(pending & ~(6'h01 << cur_chan),
        (cur_chan == 3'd5) ? 3'd5 : cur_chan + 3'd1);
    wire cal_ok = ~noise_i[cur_chan] && (cal_value_i != `CAL_VALUE_MIN)
        && (cal_value_i != `CAL_VALUE_MAX);
    wire cal_finish = (cal_state == CAL_WAIT) && cal_done_i;

    // register reads, unmapped indexes read zero
    reg [7:0] rdata;
    always @* begin
        case (idx)
            `IDX_STATUS: rdata = {7'h00, analog_cal_failed};
            `IDX_GEN_CONFIG: rdata = {7'h00, release_irq_ctrl};
            `IDX_TIMING_CONFIG: rdata = {4'h0, repeat_interval};
            `IDX_PRESS_CONFIG: rdata = {4'h0, press_thresh};
            `IDX_SAMPLE_CONFIG: rdata = {1'b0, samples_per_measure, 2'b00, cycle_time};
            `IDX_CAL_TRIGGER: rdata = {2'b00, cal_req};
            `IDX_ALERT_ENABLE: rdata = {2'b00, alert_en};
            `IDX_REPEAT_ENABLE: rdata = {2'b00, repeat_en};
            default: rdata = 8'h00;
        endcase
    end
    // calibration bits: host write, engine clear, enable set; set wins last
    always @* begin
        next_cal_req = cal_req;
        if (bus_wr && idx == `IDX_CAL_TRIGGER) begin
            next_cal_req = wbyte[5:0];
        end
        if (cal_finish && cal_ok) begin
            next_cal_req[cur_chan] = 1'b0;
        end
        next_cal_req = next_cal_req | newly_en;
    end
    // failure flag: raised at routine end, cleared by writing one
    always @* begin
        next_fail_flag = analog_cal_failed;
        if (bus_wr && idx == `IDX_STATUS && wbyte[`POS_CAL_FAILED]) begin
            next_fail_flag = 1'b0;
        end
        if (cal_finish && after_chan[3] && (routine_fail || ~cal_ok)) begin
            next_fail_flag = 1'b1;
        end
    end
    // wishbone slave: one wait state, ack for every address
    always @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
            dat_o <= 32'h0000_0000;
        end else begin
            ack_o <= bus_req;
            dat_o <= bus_req ? {24'h00_0000, rdata} : 32'h0000_0000;
        end
    end
    // configuration registers
    always @(posedge clk_i) begin
        if (rst_i) begin
            alert_en <= `RST_ALERT_ENABLE;
            repeat_en <= `RST_REPEAT_ENABLE;
            repeat_interval <= `RST_REPEAT_INTERVAL;
            press_thresh <= `RST_PRESS_THRESH;
            samples_per_measure <= `RST_SAMPLES;
            cycle_time <= `RST_CYCLE_TIME;
            release_irq_ctrl <= `RST_RELEASE_CTRL;
        end else if (bus_wr) begin
            case (idx)
                `IDX_ALERT_ENABLE: alert_en <= wbyte[5:0];
                `IDX_REPEAT_ENABLE: repeat_en <= wbyte[5:0];
                `IDX_TIMING_CONFIG: repeat_interval <= wbyte[3:0];
                `IDX_PRESS_CONFIG: press_thresh <= wbyte[3:0];
                `IDX_SAMPLE_CONFIG: begin
                    samples_per_measure <= wbyte[`POS_SAMPLES +: 3];
                    cycle_time <= wbyte[`POS_CYCLE_TIME +: 2];
                end
                `IDX_GEN_CONFIG: release_irq_ctrl <= wbyte[`POS_RELEASE_CTRL];
                default: ;
            endcase
        end
    end
    // calibration routine walks pending channels upward
    always @(posedge clk_i) begin
        if (rst_i) begin
            cal_req <= `RST_CAL_TRIGGER;
            analog_cal_failed <= 1'b0;
            eff_en_q <= 6'h00; // all enabled inputs count as new after reset
            cal_state <= CAL_IDLE;
            cur_chan <= 3'd0;
            fail_mask <= 6'h00;
            routine_fail <= 1'b0;
            cal_start_o <= 1'b0;
            cal_chan_o <= 3'd0;
        end else begin
            cal_req <= next_cal_req;
            analog_cal_failed <= next_fail_flag;
            eff_en_q <= eff_en;
            cal_start_o <= 1'b0;
            // a fresh request, or an enable in a cycle without a trigger write, retries a failed channel
            if (bus_wr && idx == `IDX_CAL_TRIGGER) begin
                fail_mask <= fail_mask & ~wbyte[5:0];
            end else begin
                fail_mask <= fail_mask & ~newly_en;
            end
            case (cal_state)
                CAL_IDLE: begin
                    routine_fail <= 1'b0;
                    if (!first_chan[3]) begin
                        cur_chan <= first_chan[2:0];
                        cal_state <= CAL_START;
                    end
                end
                CAL_START: begin
                    // a cleared bit is skipped before the engine starts it
                    if (cal_req[cur_chan]) begin
                        cal_start_o <= 1'b1;
                        cal_chan_o <= cur_chan;
                        cal_state <= CAL_WAIT;
                    end else begin
                        cal_state <= CAL_IDLE;
                    end
                end
                CAL_WAIT: begin
                    if (cal_done_i) begin
                        chan_cal_value[cur_chan] <= cal_value_i;
                        if (!cal_ok) begin
                            fail_mask[cur_chan] <= 1'b1;
                            routine_fail <= 1'b1;
                        end
                        if (after_chan[3]) begin
                            cal_state <= CAL_IDLE;
                        end else begin
                            cur_chan <= after_chan[2:0];
                            cal_state <= CAL_START;
                        end
                    end
                end
                default: cal_state <= CAL_IDLE;
            endcase
        end
    end

    // sensing cycle: sampling phase, then low power until the cycle ends
    reg [19:0] cyc_div; // cycles within one step
    reg [2:0] cyc_steps; // steps since cycle start
    reg [15:0] samp_div; // cycles within one sample unit
    reg [9:0] samp_cnt; // sample units taken
    wire [9:0] samp_total = {7'd0, n_en} << samples_per_measure;
    wire [2:0] cycle_steps = {1'b0, cycle_time} + 3'd1;
    wire cycle_done = (cyc_steps >= cycle_steps) && !sampling_o;

    always @(posedge clk_i) begin
        if (rst_i) begin
            cyc_div <= 20'd0;
            cyc_steps <= 3'd0;
            samp_div <= 16'd0;
            samp_cnt <= 10'd0;
            sampling_o <= 1'b0;
            cycle_start_o <= 1'b0;
        end else begin
            cycle_start_o <= 1'b0;
            if (cycle_done) begin
                cyc_div <= 20'd0;
                cyc_steps <= 3'd0;
                samp_div <= 16'd0;
                samp_cnt <= 10'd0;
                sampling_o <= (samp_total != 10'd0);
                cycle_start_o <= 1'b1;
            end else begin
                if (cyc_div == STEP_CYCLES - 20'd1) begin
                    cyc_div <= 20'd0;
                    // saturate so a long sampling phase cannot wrap
                    if (cyc_steps != 3'd7) begin
                        cyc_steps <= cyc_steps + 3'd1;
                    end
                end else begin
                    cyc_div <= cyc_div + 20'd1;
                end
                if (sampling_o) begin
                    if (samp_div == SAMPLE_UNIT_CYCLES - 16'd1) begin
                        samp_div <= 16'd0;
                        samp_cnt <= samp_cnt + 10'd1;
                        if (samp_cnt + 10'd1 >= samp_total) begin
                            sampling_o <= 1'b0;
                        end
                    end else begin
                        samp_div <= samp_div + 16'd1;
                    end
                end
            end
        end
    end

    assign low_power_o = !sampling_o;
    // free step tick for hold and repeat timers
    reg [19:0] tick_div;
    reg tick;
    always @(posedge clk_i) begin
        if (rst_i) begin
            tick_div <= 20'd0;
            tick <= 1'b0;
        end else begin
            tick <= (tick_div == STEP_CYCLES - 20'd1);
            tick_div <= (tick_div == STEP_CYCLES - 20'd1) ? 20'd0 : tick_div + 20'd1;
        end
    end

    // per-channel touch, release and repeat alerts
    wire [4:0] press_steps = {1'b0, press_thresh} + 5'd1;
    wire [4:0] repeat_steps = {1'b0, repeat_interval} + 5'd1;
    genvar g;
    generate
        for (g = 0; g < 6; g = g + 1) begin : chan
            reg touch_q; // previous touch status
            reg [4:0] hold_steps; // steps held, saturating
            reg [4:0] rpt_steps; // steps since last alert of a hold
            wire press = touch_status_i[g] & ~touch_q;
            wire let_go = ~touch_status_i[g] & touch_q;
            wire held_long = hold_steps > press_steps;
            wire rpt_fire = touch_q & touch_status_i[g] & tick & repeat_en[g]
                & held_long & (rpt_steps + 5'd1 >= repeat_steps);
            always @(posedge clk_i) begin
                if (rst_i) begin
                    touch_q <= 1'b0;
                    hold_steps <= 5'd0;
                    rpt_steps <= 5'd0;
                    alert_chan_o[g] <= 1'b0;
                end else begin
                    touch_q <= touch_status_i[g];
                    if (press || !touch_status_i[g]) begin
                        hold_steps <= 5'd0;
                        rpt_steps <= 5'd0;
                    end else if (tick) begin
                        if (hold_steps != 5'd31) begin
                            hold_steps <= hold_steps + 5'd1;
                        end
                        rpt_steps <= (rpt_steps + 5'd1 >= repeat_steps) ? 5'd0
                            : rpt_steps + 5'd1;
                    end
                    // bit g serves input g+1; release uses the same enable
                    alert_chan_o[g] <= alert_en[g] & (press
                        | (let_go & ~release_irq_ctrl)
                        | rpt_fire);
                end
            end
        end
    endgenerate

    assign alert_req_o = |alert_chan_o;

endmodule

`default_nettype wire

// ==== testbench/touch_chan_ctrl_properties.sv ====
// port assertions of the touch channel control
`timescale 1ns/1ps
`default_nettype none
module touch_chan_ctrl_properties #(
    parameter [19:0] STEP_CYCLES = 20,
    parameter [15:0] SAMPLE_UNIT_CYCLES = 3
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic [5:0] touch_status_i,
    input wire logic cal_start_o,
    input wire logic [2:0] cal_chan_o,
    input wire logic cal_done_i,
    input wire logic cycle_start_o,
    input wire logic sampling_o,
    input wire logic low_power_o,
    input wire logic [5:0] alert_chan_o,
    input wire logic alert_req_o
);
    // worst cycle: four steps plus six inputs at 128 samples each
    localparam int MAX_C = 4 * STEP_CYCLES + 768 * SAMPLE_UNIT_CYCLES + 8;
    int since; // clocks since the last cycle start
    // cycle length counter, restarts at every cycle start
    always @(posedge clk_i) begin
        if (rst_i || cycle_start_o) begin
            since <= 0;
        end else begin
            since <= since + 1;
        end
    end
    logic eng_busy; // a started calibration still waits for its done
    // engine busy from each start up to its done pulse
    always @(posedge clk_i) begin
        if (rst_i || cal_done_i) begin
            eng_busy <= 1'b0;
        end else if (cal_start_o) begin
            eng_busy <= 1'b1;
        end
    end
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);
    ack_pulse_a: assert property (ack_o |=> !ack_o)
        else $error("ack held over one cycle");
    bus_answer_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("request not answered next cycle");
    idle_data_a: assert property (!ack_o |-> dat_o == 32'h0000_0000)
        else $error("read data outside ack");
    low_power_a: assert property (low_power_o != sampling_o)
        else $error("low power overlaps sampling");
    alert_or_a: assert property (alert_req_o == (alert_chan_o != 6'h00))
        else $error("alert request not the channel or");
    // an alert needs a touch now or within the last three clocks
    alert_cause_a: assert property ((alert_chan_o & ~(touch_status_i | $past(touch_status_i)
        | $past(touch_status_i, 2) | $past(touch_status_i, 3))) == 6'h00)
        else $error("alert without touch on channel");
    // a held touch never keeps an alert up two cycles; a touch change may abut two
    alert_single_a: assert property ((alert_chan_o & $past(alert_chan_o) & touch_status_i
        & $past(touch_status_i)) == 6'h00)
        else $error("alert longer than one pulse");
    cal_chan_a: assert property (cal_start_o |-> cal_chan_o <= 3'h5)
        else $error("calibration of missing channel");
    cal_wait_a: assert property (cal_start_o |-> !eng_busy)
        else $error("second start before done");
    cycle_max_a: assert property (since <= MAX_C)
        else $error("sensing cycle overran");
    cal_c: cover property (cal_start_o);
    alert_c: cover property (alert_req_o);
    cycle_c: cover property (cycle_start_o);
endmodule
bind touch_chan_ctrl touch_chan_ctrl_properties #(
    .STEP_CYCLES(STEP_CYCLES),
    .SAMPLE_UNIT_CYCLES(SAMPLE_UNIT_CYCLES)
) props (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i), .dat_o(dat_o),
    .ack_o(ack_o), .touch_status_i(touch_status_i), .cal_start_o(cal_start_o),
    .cal_chan_o(cal_chan_o), .cal_done_i(cal_done_i), .cycle_start_o(cycle_start_o),
    .sampling_o(sampling_o), .low_power_o(low_power_o), .alert_chan_o(alert_chan_o),
    .alert_req_o(alert_req_o));
`default_nettype wire

// ==== testbench/cal_engine_model.sv ====
// behavioural analog calibration engine facing the control block
`timescale 1ns/1ps
`default_nettype none
module cal_engine_model (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic [7:0] delay_i,
    input wire logic [9:0] good_i,
    output logic done_o,
    output logic [9:0] value_o
);
    int cnt; // clocks left in the running calibration
    logic busy; // a calibration is running
    // value is only valid with done; otherwise it toggles so no stale value looks valid
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            busy <= 1'b0;
            cnt <= 0;
            value_o <= 10'h155;
        end else if (start_i) begin
            busy <= 1'b1;
            cnt <= delay_i;
            value_o <= ~value_o;
        end else if (busy && cnt <= 1) begin
            busy <= 1'b0;
            done_o <= 1'b1;
            value_o <= good_i;
        end else begin
            cnt <= cnt - 1;
            value_o <= ~value_o;
        end
    end
endmodule
`default_nettype wire

// ==== testbench/tb_touch_chan_ctrl.sv ====
// self-checking bench of the touch channel control
`timescale 1ns/1ps
`default_nettype none
`include "touch_ctrl_map.vh"
module tb_touch_chan_ctrl;
    localparam [19:0] STEP = 20'h0_0014; // short step keeps the run brief
    localparam [15:0] UNIT = 16'h0003; // short sample unit
    localparam logic [5:0] RI [7] = '{`IDX_ALERT_ENABLE, `IDX_REPEAT_ENABLE, `IDX_TIMING_CONFIG,
        `IDX_PRESS_CONFIG, `IDX_SAMPLE_CONFIG, `IDX_GEN_CONFIG, 6'h3f};
    localparam logic [7:0] RV [7] = '{8'h3f, 8'h3f, 8'h04, 8'h07, 8'h31, 8'h00, 8'h00};
    logic clk_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0, stb = 1'b0, we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [5:0] act_en = 6'h3f, touch = 6'h00, noise = 6'h00;
    logic [5:0] stby_en = 6'h3f; // inputs enabled in standby
    logic stby = 1'b0, sleep = 1'b0; // power state
    logic [7:0] dly = 8'h01; // calibration engine latency
    logic [9:0] good = 10'h200; // value the engine returns
    wire [31:0] rdat;
    wire ack, cal_start, cal_done, cyc_start, sampling, alert_req;
    wire [2:0] cal_chan;
    wire [9:0] cal_val;
    wire [5:0] alert_chan;
    int n_errors = 0, compares = 0;
    int acnt [6] = '{default: 0}; // alert pulses seen per channel
    int base [6];
    logic [2:0] starts [$]; // channels in calibration start order
    always #20 clk_i = ~clk_i;
    touch_chan_ctrl #(.STEP_CYCLES(STEP), .SAMPLE_UNIT_CYCLES(UNIT)) uut (.clk_i(clk_i),
        .rst_i(rst_i), .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(wdat), .dat_o(rdat), .ack_o(ack), .active_en_i(act_en), .standby_en_i(stby_en),
        .standby_i(stby), .deep_sleep_i(sleep), .touch_status_i(touch), .noise_i(noise),
        .cal_start_o(cal_start), .cal_chan_o(cal_chan), .cal_done_i(cal_done),
        .cal_value_i(cal_val), .cycle_start_o(cyc_start), .sampling_o(sampling),
        .low_power_o(), .alert_chan_o(alert_chan), .alert_req_o(alert_req));
    cal_engine_model pad (.clk_i(clk_i), .rst_i(rst_i), .start_i(cal_start), .delay_i(dly),
        .good_i(good), .done_o(cal_done), .value_o(cal_val));
    // log calibration starts and alert pulses
    always @(posedge clk_i) begin
        if (cal_start === 1'b1) begin
            starts.push_back(cal_chan);
        end
        for (int i = 0; i < 6; i++) begin
            if (alert_chan[i] === 1'b1) begin
                acnt[i]++;
            end
        end
    end
    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("mismatch at %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    // one classic wishbone cycle, held until ack is sampled
    task wb(input logic w, input logic [5:0] i, input logic [7:0] d, output logic [31:0] q);
        @(posedge clk_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {i, 2'b00};
        sel <= 4'h1;
        wdat <= {24'h00_0000, d};
        // no answer time assumed; only the watchdog ends a lost answer
        do begin
            @(posedge clk_i);
        end while (ack !== 1'b1);
        q = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask
    task wr(input logic [5:0] i, input logic [7:0] d);
        logic [31:0] q;
        wb(1'b1, i, d, q);
    endtask
    // read until the expected value shows or the tries run out
    task poll(input logic [5:0] i, input logic [7:0] e);
        logic [31:0] q;
        int n;
        n = 0;
        do begin
            wb(1'b0, i, 8'h00, q);
            n++;
        end while (q !== {24'h00_0000, e} && n < 200);
        check(q, {24'h00_0000, e});
    endtask
    task wait_cs(output int k);
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (cyc_start !== 1'b1 && k < 3000);
    endtask
    // cycle length against code and sample load
    task span(input logic [2:0] s, input logic [1:0] c);
        int k, lo, hi, smp;
        smp = 6 * (1 << s) * UNIT;
        lo = (smp > (c + 1) * STEP) ? smp : (c + 1) * STEP;
        hi = lo + 4;
        wr(`IDX_SAMPLE_CONFIG, {1'b0, s, 2'b00, c});
        repeat (3) wait_cs(k);
        check(k >= lo && k <= hi, 1'b1);
    endtask
    task press(input logic [5:0] m, input int n);
        base = acnt;
        touch <= m;
        repeat (n) @(posedge clk_i);
        touch <= 6'h00;
        repeat (12) @(posedge clk_i);
    endtask
    task conclude;
        $display("counts: %0d compares, %0d mismatches", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    // watchdog against a hung handshake
    initial begin
        repeat (40000) @(posedge clk_i);
        n_errors++;
        conclude;
    end
    initial begin
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        poll(`IDX_CAL_TRIGGER, 8'h00);
        check(starts.size(), 6);
        for (int i = 0; i < 6; i++) check(starts[i], i);
        for (int i = 0; i < 7; i++) poll(RI[i], RV[i]);
        $display("test reset done");
        noise <= 6'h04;
        wr(`IDX_CAL_TRIGGER, 8'h04);
        poll(`IDX_STATUS, 8'h01);
        poll(`IDX_CAL_TRIGGER, 8'h04);
        wr(`IDX_STATUS, 8'h01);
        noise <= 6'h00;
        good <= 10'h3ff;
        wr(`IDX_CAL_TRIGGER, 8'h10);
        poll(`IDX_STATUS, 8'h01);
        poll(`IDX_CAL_TRIGGER, 8'h10);
        wr(`IDX_STATUS, 8'h01);
        good <= 10'h200;
        wr(`IDX_CAL_TRIGGER, 8'h10);
        poll(`IDX_CAL_TRIGGER, 8'h00);
        poll(`IDX_STATUS, 8'h00);
        $display("test failure done");
        dly <= 8'h28;
        starts.delete();
        wr(`IDX_CAL_TRIGGER, 8'h30);
        wr(`IDX_CAL_TRIGGER, 8'h10);
        poll(`IDX_CAL_TRIGGER, 8'h00);
        check(starts.size(), 1);
        check(starts[0], 4);
        dly <= 8'h01;
        starts.delete();
        act_en <= 6'h3d;
        repeat (6) @(posedge clk_i);
        act_en <= 6'h3f;
        poll(`IDX_CAL_TRIGGER, 8'h00);
        check(starts.size(), 1);
        check(starts[0], 1);
        starts.delete();
        sleep <= 1'b1; // every input is new again on wake
        repeat (6) @(posedge clk_i);
        sleep <= 1'b0;
        poll(`IDX_CAL_TRIGGER, 8'h00);
        check(starts.size(), 6);
        starts.delete();
        stby_en <= 6'h1f; // entering standby drops input 6 only
        stby <= 1'b1;
        repeat (6) @(posedge clk_i);
        stby_en <= 6'h3f;
        poll(`IDX_CAL_TRIGGER, 8'h00);
        check(starts.size(), 1);
        check(starts[0], 5);
        stby <= 1'b0;
        $display("test calibration done");
        wr(`IDX_ALERT_ENABLE, 8'h05);
        for (int i = 0; i < 6; i++) begin
            press(6'h01 << i, 40);
            check(acnt[i] - base[i], (i == 0 || i == 2) ? 2 : 0);
        end
        wr(`IDX_GEN_CONFIG, 8'h01);
        press(6'h04, 40);
        check(acnt[2] - base[2], 1);
        wr(`IDX_GEN_CONFIG, 8'h00);
        wr(`IDX_PRESS_CONFIG, 8'h00);
        wr(`IDX_TIMING_CONFIG, 8'h01);
        press(6'h01, 300);
        check(acnt[0] - base[0] >= 7 && acnt[0] - base[0] <= 11, 1'b1);
        wr(`IDX_REPEAT_ENABLE, 8'h3e);
        press(6'h01, 300);
        check(acnt[0] - base[0], 2);
        $display("test alerts done");
        span(3'h0, 2'h0);
        span(3'h0, 2'h3);
        span(3'h3, 2'h0);
        $display("test cycle done");
        conclude;
    end
endmodule
`default_nettype wire
